/* logic/ffd_pkg.sv */
package ffd_pkg;

  // ****************************************
  // Register port map
  // ****************************************
  localparam int FFD_ADDR_W = 4;
  localparam logic [3:0] FFD_REG_STATUS = 4'h0;
  localparam logic [3:0] FFD_REG_DATA = 4'h1;
  localparam logic [3:0] FFD_REG_CONFIG = 4'h2;
  localparam logic [3:0] FFD_REG_CONTROL = 4'h3;
  localparam int FFD_CTRL_SRST_BIT = 0;
  localparam logic [7:0] FFD_DEV_CFG_RESET = 8'h00;
  localparam int FFD_DEV_CFG_BURST_BIT = 1;

  // ****************************************
  // Commands and parameter layout
  // ****************************************
  localparam logic [4:0] FFD_OP_SPECIFY = 5'h03;
  localparam logic [4:0] FFD_OP_WRITE = 5'h05;
  localparam logic [4:0] FFD_OP_READ = 5'h06;
  localparam logic [4:0] FFD_OP_SENSE = 5'h08;
  localparam logic [4:0] FFD_OP_CONFIG = 5'h13;
  localparam int FFD_CMD_BYTES = 9;
  localparam int FFD_RES_BYTES = 7;
  localparam logic [2:0] FFD_XFER_RES_LEN = 3'h7;
  localparam int FFD_PAR_DRIVE = 1;
  localparam int FFD_PAR_CYL = 2;
  localparam int FFD_PAR_HEAD = 3;
  localparam int FFD_PAR_SECT = 4;
  localparam int FFD_PAR_SIZE = 5;
  localparam int FFD_PAR_END_SECT = 6;
  localparam int FFD_PAR_CFG = 2;
  localparam int FFD_CFG_FIFO_OFF_BIT = 5;
  localparam logic FFD_FIFO_OFF_RESET = 1'b1;
  localparam logic [3:0] FFD_THR_RESET = 4'h0;

  // ****************************************
  // Status bits and result codes
  // ****************************************
  localparam int FFD_MSR_REQ = 7;
  localparam int FFD_MSR_DIR = 6;
  localparam int FFD_MSR_BUSY = 4;
  localparam logic [7:0] FFD_ST0_ABNORMAL = 8'h40;
  localparam logic [7:0] FFD_ST0_INVALID = 8'h80;
  localparam logic [7:0] FFD_ST1_EOC = 8'h80;
  localparam logic [7:0] FFD_ST1_OVR = 8'h10;

  // ****************************************
  // FIFO
  // ****************************************
  localparam int FFD_FIFO_DEPTH = 16;
  localparam logic [4:0] FFD_FIFO_LAST = 5'h0F;

  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_PROC = 3'b001,
    PH_EXEC = 3'b010,
    PH_DRAIN = 3'b011,
    PH_RES = 3'b100
  } ffd_phase_t;

  // Parameter bytes that follow each opcode
  function automatic logic [3:0] ffd_param_count(input logic [4:0] op);
    case (op)
      FFD_OP_READ, FFD_OP_WRITE: return 4'h8;
      FFD_OP_SPECIFY: return 4'h2;
      FFD_OP_CONFIG: return 4'h3;
      default: return 4'h0;
    endcase
  endfunction : ffd_param_count

  // Opcodes that the controller accepts
  function automatic logic ffd_opcode_valid(input logic [4:0] op);
    case (op)
      FFD_OP_READ, FFD_OP_WRITE, FFD_OP_SPECIFY, FFD_OP_SENSE, FFD_OP_CONFIG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : ffd_opcode_valid

endpackage : ffd_pkg

/* logic/ffd_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module ffd_fifo
  import ffd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FFD_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Flush empties the store
  input wire logic flush,
  // Fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  // Fill level
  output logic [$clog2(DEPTH):0] count,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // Storage
  // ****************************************
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("ffd_fifo depth must be a power of two");
  end

  // Flags and head word
  assign full = count == (AW + 1)'(DEPTH);
  assign empty = count == '0;
  assign rdata = mem[rd_ptr];

  // Data store
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr] <= wdata;
  end

  // Pointers and level
  always_ff @(posedge clk)
  begin
    if (srst || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(do_push);
      rd_ptr <= rd_ptr + AW'(do_pop);
      count <= count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    end
  end
endmodule : ffd_fifo
`default_nettype wire

/* logic/ffd_phase_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
module ffd_phase_ctl
  import ffd_pkg::*;
#(
  parameter int SECTOR_BYTES = 512
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port
  input wire logic [FFD_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt
  output logic irq,
  // DMA
  output logic dma_req,
  input wire logic dma_ack,
  input wire logic [7:0] dma_wdata,
  output logic [7:0] dma_rdata,
  input wire logic tc,
  // Disk data stream
  input wire logic disk_in_valid,
  input wire logic [7:0] disk_in_data,
  input wire logic disk_out_req,
  output logic [7:0] disk_out_data
);
  localparam int BC_W = $clog2(SECTOR_BYTES);
  localparam logic [BC_W-1:0] BC_LAST = BC_W'(SECTOR_BYTES - 1);

  if (SECTOR_BYTES < 2)
  begin : g_bad_sector
    $error("ffd_phase_ctl needs at least two bytes per sector");
  end

  // ****************************************
  // State
  // ****************************************
  ffd_phase_t phase;
  logic [7:0] cmd_buf [0:FFD_CMD_BYTES-1];
  logic [7:0] res_buf [0:FFD_RES_BYTES-1];
  logic [3:0] cmd_idx;
  logic [2:0] res_idx;
  logic [2:0] res_len;
  logic busy;
  logic invalid_pend;
  logic soft_rst;
  logic fifo_en_low;
  logic [3:0] fifo_thr;
  logic [7:0] dev_cfg;
  logic dir_read;
  logic [7:0] sector;
  logic [7:0] end_sect;
  logic [BC_W-1:0] byte_cnt;
  logic tc_seen;
  logic overrun;
  logic underrun;
  logic last_loaded;
  logic req_on;
  logic gap;
  logic [4:0] fifo_cnt;
  logic fifo_full;
  logic fifo_empty;
  logic [7:0] fifo_rdata;

  // ****************************************
  // Decode
  // ****************************************
  wire core_rst = srst || soft_rst;
  wire req_master = (phase == PH_CMD) || (phase == PH_RES);
  wire dir_to_host = phase == PH_RES;
  wire data_wr = reg_wr && (reg_addr == FFD_REG_DATA);
  wire data_rd = reg_rd && (reg_addr == FFD_REG_DATA);
  wire cmd_take = data_wr && (phase == PH_CMD);
  wire res_take = data_rd && (phase == PH_RES);
  wire [4:0] op = cmd_buf[0][4:0];
  wire proc_bad = (phase == PH_PROC) && (cmd_idx == 4'h1) && !ffd_opcode_valid(op);
  wire proc_done = (phase == PH_PROC) && !proc_bad
                   && (cmd_idx == ffd_param_count(op) + 4'h1);
  wire launch_xfer = proc_done && ((op == FFD_OP_READ) || (op == FFD_OP_WRITE));
  wire launch_sense = proc_done && (op == FFD_OP_SENSE);
  wire launch_cfg = proc_done && (op == FFD_OP_CONFIG);
  wire fifo_en = !fifo_en_low;
  wire burst = dev_cfg[FFD_DEV_CFG_BURST_BIT];

  // Transfer conditions
  wire in_exec = phase == PH_EXEC;
  wire in_xfer = in_exec || (phase == PH_DRAIN);
  wire stop = tc_seen || overrun || underrun;
  wire full_eff = fifo_en ? fifo_full : !fifo_empty;
  wire tc_now = in_xfer && dma_ack && tc;
  wire push_disk = in_exec && dir_read && disk_in_valid && !stop && !full_eff;
  wire ovr_now = in_exec && dir_read && disk_in_valid && !stop && full_eff;
  wire push_dma = in_exec && !dir_read && dma_ack && !stop && !full_eff;
  wire pop_dma = in_xfer && dir_read && dma_ack && !fifo_empty;
  wire pop_disk = in_exec && !dir_read && disk_out_req && !fifo_empty && !underrun;
  wire udr_now = in_exec && !dir_read && disk_out_req && fifo_empty && !stop;
  wire disk_byte = in_exec && (dir_read ? disk_in_valid : disk_out_req);
  wire sect_end = disk_byte && (byte_cnt == BC_LAST);
  wire tc_any = tc_seen || tc_now;
  wire ovr_any = overrun || ovr_now || underrun || udr_now;
  wire eoc_hit = !tc_any && (sector == end_sect);
  wire finish = sect_end && (tc_any || ovr_any || (sector == end_sect));
  wire go_drain = finish && dir_read && !tc_any && !ovr_any;
  wire abnormal = ovr_any || eoc_hit;
  wire [7:0] st1 = (eoc_hit ? FFD_ST1_EOC : 8'h00) | (ovr_any ? FFD_ST1_OVR : 8'h00);
  wire [7:0] st0 = (abnormal ? FFD_ST0_ABNORMAL : 8'h00)
                   | {5'h00, cmd_buf[FFD_PAR_DRIVE][2:0]};

  // DMA thresholds: the field is threshold minus one
  wire [4:0] thr_hi = FFD_FIFO_LAST - {1'b0, fifo_thr};
  wire rd_trig = !fifo_empty && (!fifo_en || (fifo_cnt >= thr_hi) || last_loaded);
  wire wr_trig = fifo_en ? (fifo_cnt <= thr_hi) : fifo_empty;
  wire rd_drop = fifo_empty || (pop_dma && (fifo_cnt == 5'h01));
  wire wr_drop = full_eff || (push_dma && (!fifo_en || fifo_cnt == FFD_FIFO_LAST));

  // ****************************************
  // FIFO
  // ****************************************
  ffd_fifo #(
    .WIDTH(8),
    .DEPTH(FFD_FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .srst(core_rst),
    .flush(!in_xfer),
    .push(push_disk || push_dma),
    .wdata(dir_read ? disk_in_data : dma_wdata),
    .pop(pop_dma || pop_disk),
    .rdata(fifo_rdata),
    .count(fifo_cnt),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // ****************************************
  // Register port
  // ****************************************
  wire [7:0] msr = {req_master, dir_to_host, 1'b0, busy, 4'h0};
  wire [7:0] rd_mux = (reg_addr == FFD_REG_STATUS) ? msr :
                      (reg_addr == FFD_REG_DATA && dir_to_host) ? res_buf[res_idx] :
                      (reg_addr == FFD_REG_CONFIG) ? dev_cfg :
                      (reg_addr == FFD_REG_CONTROL) ? {3'h0, fifo_cnt} : 8'h00;

  // Read data for one cycle, config byte and software reset
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      reg_rdata <= 8'h00;
      dev_cfg <= FFD_DEV_CFG_RESET;
      soft_rst <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      soft_rst <= reg_wr && (reg_addr == FFD_REG_CONTROL) && reg_wdata[FFD_CTRL_SRST_BIT];
      if (reg_wr && (reg_addr == FFD_REG_CONFIG))
        dev_cfg <= reg_wdata;
    end
  end

  // ****************************************
  // Phase sequencer
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      phase <= PH_CMD;
      cmd_idx <= 4'h0;
      res_idx <= 3'h0;
      res_len <= 3'h0;
      busy <= 1'b0;
      irq <= 1'b0;
      invalid_pend <= 1'b0;
      fifo_en_low <= FFD_FIFO_OFF_RESET;
      fifo_thr <= FFD_THR_RESET;
    end
    else
    begin
      case (phase)
        PH_CMD:
          if (cmd_take)
          begin
            cmd_idx <= cmd_idx + 4'h1;
            busy <= 1'b1;
            phase <= PH_PROC;
          end
        PH_PROC:
          if (proc_bad)
          begin
            irq <= 1'b1;
            invalid_pend <= 1'b1;
            busy <= 1'b0;
            cmd_idx <= 4'h0;
            phase <= PH_CMD;
          end
          else if (launch_xfer)
          begin
            cmd_idx <= 4'h0;
            phase <= PH_EXEC;
          end
          else if (launch_sense)
          begin
            irq <= 1'b0;
            invalid_pend <= 1'b0;
            res_len <= invalid_pend ? 3'h1 : 3'h2;
            cmd_idx <= 4'h0;
            phase <= PH_RES;
          end
          else if (proc_done)
          begin
            if (launch_cfg)
            begin
              fifo_en_low <= cmd_buf[FFD_PAR_CFG][FFD_CFG_FIFO_OFF_BIT];
              fifo_thr <= cmd_buf[FFD_PAR_CFG][3:0];
            end
            busy <= 1'b0;
            cmd_idx <= 4'h0;
            phase <= PH_CMD;
          end
          else
            phase <= PH_CMD;
        PH_EXEC:
          if (finish)
          begin
            res_len <= FFD_XFER_RES_LEN;
            if (go_drain)
              phase <= PH_DRAIN;
            else
            begin
              irq <= 1'b1;
              phase <= PH_RES;
            end
          end
        PH_DRAIN:
          if (fifo_empty)
          begin
            irq <= 1'b1;
            phase <= PH_RES;
          end
        PH_RES:
          if (res_take)
          begin
            irq <= 1'b0;
            if (res_idx == res_len - 3'h1)
            begin
              res_idx <= 3'h0;
              busy <= 1'b0;
              phase <= PH_CMD;
            end
            else
              res_idx <= res_idx + 3'h1;
          end
        default:
          phase <= PH_CMD;
      endcase
    end
  end

  // Command and result byte stores
  always_ff @(posedge ref_clk)
  begin
    if (cmd_take)
      cmd_buf[cmd_idx] <= reg_wdata;
    if (launch_sense)
    begin
      res_buf[0] <= invalid_pend ? FFD_ST0_INVALID : 8'h00;
      res_buf[1] <= 8'h00;
    end
    if (in_exec && finish)
    begin
      res_buf[0] <= st0;
      res_buf[1] <= st1;
      res_buf[2] <= 8'h00;
      res_buf[3] <= cmd_buf[FFD_PAR_CYL];
      res_buf[4] <= cmd_buf[FFD_PAR_HEAD];
      res_buf[5] <= sector;
      res_buf[6] <= cmd_buf[FFD_PAR_SIZE];
    end
  end

  // ****************************************
  // Execution tracking
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (core_rst || launch_xfer)
    begin
      dir_read <= launch_xfer && (op == FFD_OP_READ);
      sector <= launch_xfer ? cmd_buf[FFD_PAR_SECT] : 8'h00;
      end_sect <= launch_xfer ? cmd_buf[FFD_PAR_END_SECT] : 8'h00;
      byte_cnt <= '0;
      tc_seen <= 1'b0;
      overrun <= 1'b0;
      underrun <= 1'b0;
      last_loaded <= 1'b0;
    end
    else
    begin
      tc_seen <= tc_seen || tc_now;
      overrun <= overrun || ovr_now;
      underrun <= underrun || udr_now;
      last_loaded <= (last_loaded && !fifo_empty) || (sect_end && push_disk);
      if (sect_end)
      begin
        byte_cnt <= '0;
        if (!finish)
          sector <= sector + 8'h01;
      end
      else if (disk_byte)
        byte_cnt <= byte_cnt + BC_W'(1);
    end
  end

  // Bytes toward the disk; padding zeros once the host stops
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      disk_out_data <= 8'h00;
    else if (in_exec && disk_out_req)
      disk_out_data <= pop_disk ? fifo_rdata : 8'h00;
  end

  // ****************************************
  // DMA request
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (core_rst || !in_xfer || stop || tc_now)
      req_on <= 1'b0;
    else if (dir_read)
      req_on <= req_on ? !rd_drop : rd_trig;
    else
      req_on <= req_on ? !wr_drop : (in_exec && wr_trig && !full_eff);
  end

  // Single mode leaves one idle cycle after each acknowledge
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      gap <= 1'b0;
    else
      gap <= dma_ack && !burst;
  end

  assign dma_req = req_on && !gap;
  assign dma_rdata = fifo_rdata;

  // ****************************************
  // Checks
  // ****************************************
  a_reset_phase: assert property (@(posedge ref_clk) srst |=> phase == PH_CMD && req_master && !dir_to_host)
    else $error("controller not in command phase after reset");

  a_req_drop: assert property (@(posedge ref_clk) disable iff (core_rst) cmd_take |=> !req_master)
    else $error("request flag stayed up after a command byte");

  a_last_param: assert property (@(posedge ref_clk) disable iff (core_rst)
    launch_xfer |=> !req_master && phase == PH_EXEC)
    else $error("request flag not held low after final parameter");

  a_fifo_idle: assert property (@(posedge ref_clk) disable iff (core_rst)
    phase == PH_CMD |-> fifo_empty)
    else $error("FIFO holds data in command phase");

  a_rd_threshold: assert property (@(posedge ref_clk) disable iff (core_rst)
    in_xfer && dir_read && !stop && !tc_now && !req_on && fifo_en && !fifo_empty
    && fifo_cnt >= FFD_FIFO_LAST - {1'b0, fifo_thr} |=> req_on)
    else $error("read request missing at threshold");

  a_rd_empty: assert property (@(posedge ref_clk) disable iff (core_rst)
    in_xfer && dir_read && fifo_empty |=> !dma_req)
    else $error("read request held with empty FIFO");

  a_wr_entry: assert property (@(posedge ref_clk) disable iff (core_rst)
    launch_xfer && op == FFD_OP_WRITE |=> ##1 dma_req)
    else $error("write request not raised on entering execution");

  a_tc_stop: assert property (@(posedge ref_clk) disable iff (core_rst)
    tc_now |=> !dma_req [*3])
    else $error("DMA request after terminal count");

  a_irq_result: assert property (@(posedge ref_clk) disable iff (core_rst)
    $past(in_xfer) && phase == PH_RES |-> irq)
    else $error("result phase entered without interrupt");

  a_res_done: assert property (@(posedge ref_clk) disable iff (core_rst)
    res_take && res_idx == res_len - 3'h1 |=> req_master && !dir_to_host && !busy)
    else $error("status not ready after last result byte");

  a_invalid_irq: assert property (@(posedge ref_clk) disable iff (core_rst)
    cmd_take && cmd_idx == 4'h0 && !ffd_opcode_valid(reg_wdata[4:0]) |=> ##1 irq && phase == PH_CMD)
    else $error("invalid opcode did not interrupt");

  a_single_gap: assert property (@(posedge ref_clk) disable iff (core_rst)
    dma_ack && !burst |=> !dma_req)
    else $error("single mode request without idle cycle");
endmodule : ffd_phase_ctl
`default_nettype wire

/* verif/ffd_dma_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ffd_dma_model
  import ffd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Job set up by the bench
  input wire logic run,
  input wire logic to_disk,
  input wire logic [4:0] n_bytes,
  input wire logic [7:0] seed_byte,
  // Request line
  input wire logic dma_req,
  input wire logic [7:0] dma_rdata,
  output logic dma_ack,
  output logic [7:0] dma_wdata,
  output logic tc,
  output logic [4:0] moved
);
  logic [7:0] got [16];

  // One byte per ack, idle cycle after each, random stalls, stop after n_bytes with tc on the last byte toward the disk
  always_ff @(posedge ref_clk)
  begin
    if (srst || !run)
    begin
      dma_ack <= 1'b0;
      tc <= 1'b0;
      moved <= 5'h00;
      dma_wdata <= 8'hA5;
    end
    else if (dma_ack)
    begin
      if (!to_disk)
        got[moved] <= dma_rdata;
      moved <= moved + 5'h01;
      dma_ack <= 1'b0;
      tc <= 1'b0;
      dma_wdata <= ~dma_wdata; // Released bus never shows the old byte
    end
    else if (dma_req && moved < n_bytes && $urandom_range(0, 3) != 0)
    begin
      dma_ack <= 1'b1;
      dma_wdata <= seed_byte + 8'(moved);
      tc <= to_disk && (moved == n_bytes - 5'h01);
    end
  end
endmodule : ffd_dma_model
`default_nettype wire

/* verif/ffd_phase_ctl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ffd_phase_ctl_tb_top
  import ffd_pkg::*;
;
  localparam int SEC = 4;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [FFD_ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, dma_wdata, dma_rdata, disk_out_data, rd;
  logic irq, dma_req, dma_ack, tc;
  logic disk_in_valid = 1'b0;
  logic [7:0] disk_in_data = 8'h00;
  logic disk_out_req = 1'b0;
  logic run = 1'b0;
  logic to_disk = 1'b0;
  logic [4:0] n_bytes = 5'h00;
  logic [7:0] seed_byte = 8'h00;
  logic [4:0] moved;
  logic [7:0] par [9];
  logic [7:0] res [7];
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #20 ref_clk = ~ref_clk;

  ffd_phase_ctl #(.SECTOR_BYTES(SEC)) i_dut (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .tc(tc), .disk_in_valid(disk_in_valid),
    .disk_in_data(disk_in_data), .disk_out_req(disk_out_req), .disk_out_data(disk_out_data));

  ffd_dma_model i_dma (.ref_clk(ref_clk), .srst(srst), .run(run), .to_disk(to_disk),
    .n_bytes(n_bytes), .seed_byte(seed_byte), .dma_req(dma_req), .dma_rdata(dma_rdata),
    .dma_ack(dma_ack), .dma_wdata(dma_wdata), .tc(tc), .moved(moved));

  // ****************************************
  // Bus cycles and checks
  // ****************************************
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rd_reg

  // Write, optionally followed at once by a status read
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic peek);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (peek)
    begin
      reg_addr <= FFD_REG_STATUS;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata & 8'h80, 8'h00);
    end
  endtask : wr_reg

  task automatic poll(input logic [7:0] exp);
    int n;
    n = 0;
    rd = ~exp;
    while ((rd & 8'hC0) !== exp && n < 60)
    begin
      rd_reg(FFD_REG_STATUS);
      n++;
    end
    check(rd & 8'hC0, exp);
  endtask : poll

  task automatic send(input int n, input logic exec);
    for (int i = 0; i < n; i++)
    begin
      poll(8'h80);
      wr_reg(FFD_REG_DATA, par[i], 1'b1);
    end
    if (exec)
    begin
      rd_reg(FFD_REG_STATUS);
      check(rd & 8'h80, 8'h00);
    end
  endtask : send

  task automatic results(input int n);
    for (int i = 0; i < n; i++)
    begin
      poll(8'hC0);
      rd_reg(FFD_REG_DATA);
      res[i] = rd;
    end
    rd_reg(FFD_REG_STATUS);
    check(rd, 8'h80);
  endtask : results

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 600)
    begin
      @(posedge ref_clk);
      n++;
    end
    check({7'h00, irq}, 8'h01);
  endtask : wait_irq

  // One sector, start sector equal to end sector
  task automatic xfer(input logic wr_dir, input logic fifo_on);
    logic [7:0] sb;
    sb = 8'($urandom);
    run <= 1'b0;
    to_disk <= wr_dir;
    n_bytes <= wr_dir ? 5'h04 : 5'h10;
    seed_byte <= sb;
    par[0] = {3'h0, wr_dir ? FFD_OP_WRITE : FFD_OP_READ};
    for (int i = 1; i < 9; i++)
      par[i] = 8'($urandom);
    par[1] = {6'h00, par[1][1:0]};
    par[6] = par[4];
    send(9, 1'b1);
    run <= 1'b1;
    if (wr_dir)
    begin
      repeat (24) @(posedge ref_clk);
      rd_reg(FFD_REG_CONTROL);
      check(rd, fifo_on ? 8'h04 : 8'h01);
      for (int i = 0; i < SEC; i++)
      begin
        repeat (8) @(posedge ref_clk);
        disk_out_req <= 1'b1;
        @(posedge ref_clk);
        disk_out_req <= 1'b0;
        #1 check(disk_out_data, sb + 8'(i));
      end
    end
    else
      for (int i = 0; i < SEC; i++)
      begin
        repeat (5) @(posedge ref_clk);
        disk_in_valid <= 1'b1;
        disk_in_data <= sb + 8'(i);
        @(posedge ref_clk);
        disk_in_valid <= 1'b0;
      end
    wait_irq();
    if (!wr_dir)
    begin
      check({3'h0, moved}, 8'h04);
      for (int i = 0; i < SEC; i++)
        check(i_dma.got[i], sb + 8'(i));
    end
    results(7);
    check(res[0], {6'h00, par[1][1:0]} | (wr_dir ? 8'h00 : FFD_ST0_ABNORMAL));
    check(res[1], wr_dir ? 8'h00 : FFD_ST1_EOC);
    check(res[3], par[2]);
    check(res[4], par[3]);
  endtask : xfer

  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(92168));
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    rd_reg(FFD_REG_STATUS);
    check(rd, 8'h80);
    rd_reg(FFD_REG_CONTROL);
    check(rd, 8'h00);
    rd_reg(FFD_REG_CONFIG);
    check(rd, FFD_DEV_CFG_RESET);
    rd_reg(4'hC);
    check(rd, 8'h00);
    do
      par[0] = {3'h0, 5'($urandom)};
    while (par[0] inside {8'h03, 8'h05, 8'h06, 8'h08, 8'h13});
    send(1, 1'b0);
    wait_irq();
    par[0] = {3'h0, FFD_OP_SENSE};
    send(1, 1'b0);
    results(1);
    check(res[0], FFD_ST0_INVALID);
    check({7'h00, irq}, 8'h00);
    xfer(1'b1, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(FFD_REG_CONFIG, {6'h00, k[0], 1'b0}, 1'b0);
      rd_reg(FFD_REG_CONFIG);
      check(rd, {6'h00, k[0], 1'b0});
      par[0] = {3'h0, FFD_OP_CONFIG};
      par[1] = 8'($urandom);
      par[2] = {4'h0, k == 0 ? 4'hF : 4'($urandom)};
      par[3] = 8'($urandom);
      send(4, 1'b0);
      xfer(1'b0, 1'b1);
      xfer(1'b1, 1'b1);
    end
    send(3, 1'b0);
    wr_reg(FFD_REG_CONTROL, 8'h01, 1'b0);
    rd_reg(FFD_REG_STATUS);
    check(rd, 8'h80);
    rd_reg(FFD_REG_CONFIG);
    check(rd, 8'h02);
    test_done();
  end
endmodule : ffd_phase_ctl_tb_top
`default_nettype wire
